/* File: hw/srpm_ctrl.sv */
// Supply regulator setting and power mode control, top level.
// Assumes a synchronous host register port and synchronous enables.
`timescale 1ns/1ps
`include "srpm_defines.svh"
module srpm_ctrl
    import srpm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic main_enable_i,
    input wire logic aux_wake_pin_i,
    input wire srpm_mv_t input_supply_rail_mv_i,
    output logic [7:0] reg_rdata_o,
    output logic auto_mode_o,
    output srpm_mv_t margin_mv_o,
    output srpm_mv_t rf_amp_supply_rail_mv_o,
    output srpm_mv_t analog_rail_mv_o,
    output srpm_mv_t digital_rail_mv_o,
    output logic adjust_run_o,
    output srpm_pwr_e pwr_state_o,
    output logic regulators_on_o,
    output logic osc_on_o,
    output logic host_clock_output_hf_o,
    output logic host_clock_output_aux_o,
    output logic digital_rail_on_o,
    output logic tx_on_o,
    output logic rx_on_o,
    output logic standby_o
);

    ////////////////////////////////////////////////////////////////////
    // Register file

    logic [7:0] chip_status_reg;
    logic [7:0] chip_status_next;
    logic [7:0] reg_ctrl_reg;
    logic [7:0] reg_ctrl_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic wr_cs;
    logic wr_rc;

    always_comb begin
        wr_cs = reg_wr_i && (reg_addr_i == `SRPM_ADDR_CHIP_STATUS);
        wr_rc = reg_wr_i && (reg_addr_i == `SRPM_ADDR_REG_CTRL);
        chip_status_next = wr_cs ? reg_wdata_i : chip_status_reg;
        reg_ctrl_next = wr_rc ? reg_wdata_i : reg_ctrl_reg;
        // Unmapped offsets read as zero
        unique case (reg_addr_i)
            `SRPM_ADDR_CHIP_STATUS: rdata_next = chip_status_reg;
            `SRPM_ADDR_REG_CTRL: rdata_next = reg_ctrl_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            chip_status_reg <= `SRPM_CS_RESET;
            reg_ctrl_reg <= `SRPM_RC_RESET;
            rdata_reg <= 8'h00;
        end else begin
            chip_status_reg <= chip_status_next;
            reg_ctrl_reg <= reg_ctrl_next;
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Setpoint decode and automatic adjustment runs

    srpm_if dec_bus ();

    assign dec_bus.reg_ctrl = reg_ctrl_reg;
    assign dec_bus.class_5v = chip_status_reg[`SRPM_CS_CLASS_BIT];
    assign dec_bus.vin_mv = input_supply_rail_mv_i;

    srpm_decode u_decode (
        .bus(dec_bus.dec)
    );

    logic auto_q_reg;
    logic auto_q_next;
    logic en_q_reg;
    logic en_q_next;
    logic run_start;
    logic run_reg;
    logic auto_reg;
    srpm_mv_t margin_reg;
    srpm_mv_t margin_next;
    srpm_mv_t rf_reg;
    srpm_mv_t rf_next;
    srpm_mv_t an_reg;
    srpm_mv_t an_next;
    srpm_mv_t dg_reg;
    srpm_mv_t dg_next;

    always_comb begin
        auto_q_next = reg_ctrl_reg[`SRPM_RC_AUTO_BIT];
        en_q_next = main_enable_i;
        // Level-held auto bit must not retrigger; only edges start a run
        run_start = reg_ctrl_reg[`SRPM_RC_AUTO_BIT] &&
            (!auto_q_reg || (main_enable_i && !en_q_reg));
        margin_next = dec_bus.margin_mv;
        if (!reg_ctrl_reg[`SRPM_RC_AUTO_BIT] || run_start) begin
            rf_next = dec_bus.rf_mv;
            an_next = dec_bus.an_mv;
            dg_next = dec_bus.dg_mv;
        end else begin
            // Automatic result holds between runs, even if input drifts
            rf_next = rf_reg;
            an_next = an_reg;
            dg_next = dg_reg;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            auto_q_reg <= 1'b1;
            en_q_reg <= 1'b0;
            run_reg <= 1'b0;
            auto_reg <= 1'b1;
            margin_reg <= `SRPM_MARGIN_250_MV;
            rf_reg <= 13'h0000;
            an_reg <= 13'h0000;
            dg_reg <= 13'h0000;
        end else begin
            auto_q_reg <= auto_q_next;
            en_q_reg <= en_q_next;
            run_reg <= run_start;
            auto_reg <= auto_q_next;
            margin_reg <= margin_next;
            rf_reg <= rf_next;
            an_reg <= an_next;
            dg_reg <= dg_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Power state

    srpm_pwr_e pwr_reg;
    srpm_pwr_e pwr_next;
    logic [6:0] pwr_out_reg;
    logic [6:0] pwr_out_next;
    logic rf_all;
    logic rx_only;
    logic standby_reg;
    logic standby_next;

    always_comb begin
        rf_all = chip_status_reg[`SRPM_CS_RF_BIT];
        rx_only = chip_status_reg[`SRPM_CS_RX_BIT];
        if (main_enable_i) begin
            pwr_next = chip_status_reg[`SRPM_CS_STBY_BIT] ?
                SRPM_PWR_STANDBY : SRPM_PWR_ACTIVE;
        end else if (aux_wake_pin_i) begin
            pwr_next = SRPM_PWR_SLEEP;
        end else begin
            pwr_next = SRPM_PWR_DOWN;
        end
        // {regs, osc, hf clk, aux clk, dig rail, tx, rx}
        unique case (pwr_next)
            SRPM_PWR_ACTIVE: pwr_out_next = {5'b11101, rf_all,
                rf_all || rx_only};
            SRPM_PWR_STANDBY: pwr_out_next = 7'h74;
            SRPM_PWR_SLEEP: pwr_out_next = 7'h0c;
            SRPM_PWR_DOWN: pwr_out_next = 7'h00;
        endcase
        standby_next = (pwr_next == SRPM_PWR_STANDBY);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pwr_reg <= SRPM_PWR_DOWN;
            pwr_out_reg <= 7'h00;
            standby_reg <= 1'b0;
        end else begin
            pwr_reg <= pwr_next;
            pwr_out_reg <= pwr_out_next;
            standby_reg <= standby_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign auto_mode_o = auto_reg;
    assign margin_mv_o = margin_reg;
    assign rf_amp_supply_rail_mv_o = rf_reg;
    assign analog_rail_mv_o = an_reg;
    assign digital_rail_mv_o = dg_reg;
    assign adjust_run_o = run_reg;
    assign pwr_state_o = pwr_reg;
    assign regulators_on_o = pwr_out_reg[6];
    assign osc_on_o = pwr_out_reg[5];
    assign host_clock_output_hf_o = pwr_out_reg[4];
    assign host_clock_output_aux_o = pwr_out_reg[3];
    assign digital_rail_on_o = pwr_out_reg[2];
    assign tx_on_o = pwr_out_reg[1];
    assign rx_on_o = pwr_out_reg[0];
    assign standby_o = standby_reg;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic cs_written_reg;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_written_reg <= 1'b0;
        end else if (wr_cs) begin
            cs_written_reg <= 1'b1;
        end
    end

    chk_class_reset_5v: assert property (
        !cs_written_reg |-> chip_status_reg[`SRPM_CS_CLASS_BIT])
        else $error("class bit left 5 V without a write");
    chk_class_write_only: assert property (
        !wr_cs |=> $stable(chip_status_reg[`SRPM_CS_CLASS_BIT]))
        else $error("class bit changed without a write");
    chk_auto_mode_follow: assert property (
        wr_rc |=> ##1 auto_mode_o == $past(reg_wdata_i[7], 2))
        else $error("auto mode output does not follow write");
    chk_margin_250: assert property (
        reg_ctrl_reg[1:0] == 2'b11 |=> margin_mv_o == `SRPM_MARGIN_250_MV)
        else $error("margin pattern 11 not 250 mV");
    chk_manual_5v: assert property (
        !reg_ctrl_reg[7] && chip_status_reg[0] |=>
        rf_amp_supply_rail_mv_o == $past(`SRPM_RF5_BASE_MV +
        srpm_mv_t'({10'h000, reg_ctrl_reg[2:0]}) * `SRPM_STEP_MV) &&
        analog_rail_mv_o == `SRPM_AD_FIX_MV)
        else $error("manual 5 V decode wrong");
    chk_manual_3v: assert property (
        !reg_ctrl_reg[7] && !chip_status_reg[0] |=>
        analog_rail_mv_o == rf_amp_supply_rail_mv_o &&
        digital_rail_mv_o == rf_amp_supply_rail_mv_o &&
        rf_amp_supply_rail_mv_o >= `SRPM_LV_BASE_MV &&
        rf_amp_supply_rail_mv_o <= `SRPM_AD_CAP_MV)
        else $error("manual 3 V decode wrong");
    chk_auto_caps: assert property (
        adjust_run_o |-> rf_amp_supply_rail_mv_o <= `SRPM_RF_CAP_MV &&
        analog_rail_mv_o <= `SRPM_AD_CAP_MV &&
        digital_rail_mv_o == analog_rail_mv_o &&
        (rf_amp_supply_rail_mv_o == `SRPM_RF_CAP_MV ||
        rf_amp_supply_rail_mv_o == 13'h0000 ||
        srpm_mv_t'(rf_amp_supply_rail_mv_o + margin_mv_o) ==
        $past(input_supply_rail_mv_i)) &&
        analog_rail_mv_o == ((rf_amp_supply_rail_mv_o > `SRPM_AD_CAP_MV) ?
        `SRPM_AD_CAP_MV : rf_amp_supply_rail_mv_o))
        else $error("automatic target wrong or above cap");
    chk_run_on_rise: assert property (
        $rose(reg_ctrl_reg[7]) || (reg_ctrl_reg[7] &&
        $rose(main_enable_i)) |=> adjust_run_o)
        else $error("automatic run not started");
    chk_enable_power: assert property (
        main_enable_i |=> regulators_on_o && osc_on_o &&
        host_clock_output_hf_o)
        else $error("main enable did not power up");
    chk_standby_bit: assert property (
        main_enable_i && chip_status_reg[7] |=> standby_o && !tx_on_o)
        else $error("standby bit not honoured");
    chk_ignore_io_bits: assert property (
        $stable(reg_ctrl_reg[7]) && $stable(reg_ctrl_reg[2:0]) &&
        $stable(chip_status_reg[0]) && !run_start |=>
        $stable(rf_amp_supply_rail_mv_o))
        else $error("rail moved without a cause");

    cov_auto_run: cover property ($rose(adjust_run_o));
    cov_standby: cover property (pwr_state_o == SRPM_PWR_STANDBY);
    cov_sleep: cover property (pwr_state_o == SRPM_PWR_SLEEP);
    cov_manual_3v_top: cover property (!reg_ctrl_reg[7] &&
        !chip_status_reg[0] && reg_ctrl_reg[2:0] == 3'h7);

endmodule : srpm_ctrl

/* File: hw/srpm_decode.sv */
// Combinational decode of regulator setpoints in millivolts.
// Assumes the caller registers the results and gates auto runs.
`timescale 1ns/1ps
`include "srpm_defines.svh"
module srpm_decode
    import srpm_pkg::*;
(
    srpm_if.dec bus
);

    function automatic srpm_mv_t srpm_auto_target(input srpm_mv_t input_supply_rail,
        input srpm_mv_t margin, input srpm_mv_t cap);
        srpm_mv_t diff;
        diff = (input_supply_rail > margin) ? srpm_mv_t'(input_supply_rail - margin) : 13'h0000;
        return (diff > cap) ? cap : diff;
    endfunction : srpm_auto_target

    srpm_mv_t step;

    always_comb begin
        step = srpm_mv_t'({10'h000, bus.reg_ctrl[2:0]} * `SRPM_STEP_MV);
        // Bits 6..3 are I/O controls, never looked at here
        unique case (bus.reg_ctrl[1:0])
            2'b11: bus.margin_mv = `SRPM_MARGIN_250_MV;
            2'b10: bus.margin_mv = `SRPM_MARGIN_350_MV;
            default: bus.margin_mv = `SRPM_MARGIN_400_MV;
        endcase
        if (bus.reg_ctrl[`SRPM_RC_AUTO_BIT]) begin
            bus.rf_mv = srpm_auto_target(bus.vin_mv, bus.margin_mv,
                `SRPM_RF_CAP_MV);
            bus.an_mv = srpm_auto_target(bus.vin_mv, bus.margin_mv,
                `SRPM_AD_CAP_MV);
            bus.dg_mv = bus.an_mv;
        end else if (bus.class_5v) begin
            bus.rf_mv = srpm_mv_t'(`SRPM_RF5_BASE_MV + step);
            bus.an_mv = `SRPM_AD_FIX_MV;
            bus.dg_mv = `SRPM_AD_FIX_MV;
        end else begin
            bus.rf_mv = srpm_mv_t'(`SRPM_LV_BASE_MV + step);
            bus.an_mv = bus.rf_mv;
            bus.dg_mv = bus.rf_mv;
        end
    end

endmodule : srpm_decode

/* File: hw/srpm_defines.svh */
// Register offsets, field positions, reset values and voltage figures
// for the supply regulator and power mode control block.
// Assumes inclusion by bare name; definitions only.
`ifndef SRPM_DEFINES_SVH
`define SRPM_DEFINES_SVH

`define SRPM_ADDR_CHIP_STATUS 8'h00
`define SRPM_ADDR_REG_CTRL 8'h0b

`define SRPM_CS_RESET 8'h01
`define SRPM_RC_RESET 8'h87

`define SRPM_CS_CLASS_BIT 0
`define SRPM_CS_RX_BIT 1
`define SRPM_CS_RF_BIT 5
`define SRPM_CS_STBY_BIT 7
`define SRPM_RC_AUTO_BIT 7

`define SRPM_RF5_BASE_MV 13'h10cc
`define SRPM_LV_BASE_MV 13'h0a8c
`define SRPM_STEP_MV 13'h0064
`define SRPM_AD_FIX_MV 13'h0d48
`define SRPM_RF_CAP_MV 13'h1388
`define SRPM_AD_CAP_MV 13'h0d48
`define SRPM_MARGIN_250_MV 13'h00fa
`define SRPM_MARGIN_350_MV 13'h015e
`define SRPM_MARGIN_400_MV 13'h0190

`endif

/* File: hw/srpm_if.sv */
// Carrier between control registers and the voltage decoder.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface srpm_if;
    import srpm_pkg::*;
    logic [7:0] reg_ctrl;
    logic class_5v;
    srpm_mv_t vin_mv;
    srpm_mv_t margin_mv;
    srpm_mv_t rf_mv;
    srpm_mv_t an_mv;
    srpm_mv_t dg_mv;
    modport ctrl (output reg_ctrl, output class_5v, output vin_mv,
        input margin_mv, input rf_mv, input an_mv, input dg_mv);
    modport dec (input reg_ctrl, input class_5v, input vin_mv,
        output margin_mv, output rf_mv, output an_mv, output dg_mv);
endinterface : srpm_if

/* File: hw/srpm_pkg.sv */
// Types shared by the regulator control block.
// Assumes the defines header supplies all numeric figures.
package srpm_pkg;

    typedef logic [12:0] srpm_mv_t;

    typedef enum logic [1:0] {
        SRPM_PWR_DOWN = 2'b00,
        SRPM_PWR_SLEEP = 2'b01,
        SRPM_PWR_STANDBY = 2'b10,
        SRPM_PWR_ACTIVE = 2'b11
    } srpm_pwr_e;

endpackage : srpm_pkg

/* File: test/srpm_ctrl_tb_top.sv */
// Self-checking bench for the regulator and power mode control block.
// Assumes the host model as the only driver of the register port.
`timescale 1ns/1ps
module srpm_ctrl_tb_top
    import srpm_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic reg_wr, main_en, aux_wake, auto_mode, adjust_run, reg_on, osc_on;
    logic hf_clk, aux_clk, dig_on, tx_on, rx_on, standby;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
    srpm_mv_t input_supply_rail, margin, rf_mv, an_mv, dg_mv;
    srpm_pwr_e pwr;
    int num_errors = 0;
    int checks = 0;
    int i;
    logic [7:0] acode [3] = '{8'h87, 8'h86, 8'h84};
    srpm_mv_t amar [3] = '{13'h00fa, 13'h015e, 13'h0190};

    always #20 clk_i = ~clk_i;

    srpm_host_model srpm_host_model_inst (.clk_i(clk_i),
        .reg_rdata_i(reg_rdata), .reg_wr_o(reg_wr), .reg_addr_o(reg_addr),
        .reg_wdata_o(reg_wdata), .main_enable_o(main_en),
        .aux_wake_pin_o(aux_wake), .input_supply_rail_mv_o(input_supply_rail));

    srpm_ctrl srpm_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
        .reg_wr_i(reg_wr), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .main_enable_i(main_en), .aux_wake_pin_i(aux_wake),
        .input_supply_rail_mv_i(input_supply_rail), .reg_rdata_o(reg_rdata),
        .auto_mode_o(auto_mode), .margin_mv_o(margin),
        .rf_amp_supply_rail_mv_o(rf_mv), .analog_rail_mv_o(an_mv),
        .digital_rail_mv_o(dg_mv), .adjust_run_o(adjust_run),
        .pwr_state_o(pwr), .regulators_on_o(reg_on), .osc_on_o(osc_on),
        .host_clock_output_hf_o(hf_clk), .host_clock_output_aux_o(aux_clk),
        .digital_rail_on_o(dig_on), .tx_on_o(tx_on), .rx_on_o(rx_on),
        .standby_o(standby));

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk_bit(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit

    task automatic chk_byte(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_byte

    task automatic chk_mv(input string nm, input srpm_mv_t e,
        input srpm_mv_t g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk_mv

    task automatic chk_rails(input srpm_mv_t rf, input srpm_mv_t an);
        chk_mv("rf rail", rf, rf_mv);
        chk_mv("analog rail", an, an_mv);
        chk_mv("digital rail", an, dg_mv);
    endtask : chk_rails

    task automatic chk_pwr(input srpm_pwr_e st, input logic on,
        input logic aux, input logic dig, input logic tx, input logic rx,
        input logic sb);
        chk_byte("pwr state", {6'h00, st}, {6'h00, pwr});
        chk_bit("regulators on", on, reg_on);
        chk_bit("osc on", on, osc_on);
        chk_bit("hf clock", on, hf_clk);
        chk_bit("aux clock", aux, aux_clk);
        chk_bit("digital rail on", dig, dig_on);
        chk_bit("tx on", tx, tx_on);
        chk_bit("rx on", rx, rx_on);
        chk_bit("standby", sb, standby);
    endtask : chk_pwr

    // Counts run pulses over a window that covers the documented latency
    task automatic watch_run(input int e);
        int n;
        n = 0;
        repeat (6) begin
            @(posedge clk_i);
            #1;
            if (adjust_run === 1'b1) n++;
        end
        chk_byte("adjust runs", e[7:0], n[7:0]);
    endtask : watch_run

    task automatic settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : settle

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(40 * 4000);
        num_errors++;
        end_of_test();
    end

    initial begin
        repeat (12) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        srpm_host_model_inst.read_reg(8'h00, rd);
        chk_byte("chip status", 8'h01, rd);
        srpm_host_model_inst.read_reg(8'h0b, rd);
        chk_byte("reg ctrl", 8'h87, rd);
        srpm_host_model_inst.read_reg(8'h05, rd);
        chk_byte("unmapped", 8'h00, rd);
        chk_bit("auto mode", 1'b1, auto_mode);
        chk_pwr(SRPM_PWR_DOWN, 0, 0, 0, 0, 0, 0);
        srpm_host_model_inst.set_pins(1'b1, 1'b0);
        watch_run(1);
        chk_rails(13'h1388, 13'h0d48);
        chk_pwr(SRPM_PWR_ACTIVE, 1, 0, 1, 0, 0, 0);
        srpm_host_model_inst.program_default();
        watch_run(0);
        srpm_host_model_inst.set_supply(13'h0dac, 8'h20);
        for (i = 0; i < 3; i++) begin
            srpm_host_model_inst.rerun_auto(acode[i]);
            watch_run(1);
            chk_mv("margin", amar[i], margin);
            chk_rails(13'h0dac - amar[i], 13'h0dac - amar[i]);
        end
        chk_pwr(SRPM_PWR_ACTIVE, 1, 0, 1, 1, 1, 0);
        for (i = 0; i < 8; i++) begin
            srpm_host_model_inst.write_reg(8'h0b, {5'h0f, i[2:0]});
            settle();
            chk_bit("auto mode", 1'b0, auto_mode);
            chk_rails(13'h0a8c + 13'h0064 * i[12:0],
                13'h0a8c + 13'h0064 * i[12:0]);
        end
        srpm_host_model_inst.set_supply(13'h12c0, 8'h02);
        settle();
        chk_rails(13'h10cc + 13'h02bc, 13'h0d48);
        chk_pwr(SRPM_PWR_ACTIVE, 1, 0, 1, 0, 1, 0);
        for (i = 0; i < 8; i++) begin
            srpm_host_model_inst.write_reg(8'h0b, {5'h0f, i[2:0]});
            settle();
            chk_rails(13'h10cc + 13'h0064 * i[12:0], 13'h0d48);
        end
        srpm_host_model_inst.set_supply(13'h12c0, 8'h80);
        settle();
        chk_pwr(SRPM_PWR_STANDBY, 1, 0, 1, 0, 0, 1);
        srpm_host_model_inst.read_reg(8'h00, rd);
        chk_byte("chip status", 8'h81, rd);
        srpm_host_model_inst.set_pins(1'b0, 1'b1);
        settle();
        chk_pwr(SRPM_PWR_SLEEP, 0, 1, 1, 0, 0, 0);
        srpm_host_model_inst.set_pins(1'b0, 1'b0);
        settle();
        chk_pwr(SRPM_PWR_DOWN, 0, 0, 0, 0, 0, 0);
        srpm_host_model_inst.write_reg(8'h05, 8'hff);
        srpm_host_model_inst.read_reg(8'h0b, rd);
        chk_byte("reg ctrl", 8'h7f, rd);
        srpm_host_model_inst.read_reg(8'h05, rd);
        chk_byte("unmapped", 8'h00, rd);
        // Enable rise in manual mode must not start a run
        srpm_host_model_inst.set_pins(1'b1, 1'b0);
        watch_run(0);
        srpm_host_model_inst.program_default();
        watch_run(1);
        chk_rails(13'h11c6, 13'h0d48);
        srpm_host_model_inst.rerun_auto(8'h85);
        watch_run(1);
        chk_mv("margin", 13'h0190, margin);
        chk_rails(13'h1130, 13'h0d48);
        // Reset after the run has ended, with main enable held high
        @(posedge clk_i);
        #1;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        watch_run(1);
        chk_rails(13'h11c6, 13'h0d48);
        srpm_host_model_inst.read_reg(8'h00, rd);
        chk_byte("chip status", 8'h01, rd);
        srpm_host_model_inst.read_reg(8'h0b, rd);
        chk_byte("reg ctrl", 8'h87, rd);
        end_of_test();
    end
endmodule : srpm_ctrl_tb_top

/* File: test/srpm_host_model.sv */
// Host microcontroller model: register writes, reads and enable pins.
// Assumes the register port samples on the rising edge of clk_i.
`timescale 1ns/1ps
module srpm_host_model
    import srpm_pkg::*;
(
    input wire logic clk_i,
    input wire logic [7:0] reg_rdata_i,
    output logic reg_wr_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic main_enable_o,
    output logic aux_wake_pin_o,
    output srpm_mv_t input_supply_rail_mv_o
);
    initial begin
        reg_wr_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
        main_enable_o = 1'b0;
        aux_wake_pin_o = 1'b0;
        input_supply_rail_mv_o = 13'h1518;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_i);
        #1;
        reg_wr_o = 1'b1;
        reg_addr_o = addr;
        reg_wdata_o = data;
        @(posedge clk_i);
        #1;
        reg_wr_o = 1'b0;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk_i);
        #1;
        reg_addr_o = addr;
        @(posedge clk_i);
        #1;
        data = reg_rdata_i;
    endtask : read_reg

    task automatic set_pins(input logic en, input logic aux);
        @(posedge clk_i);
        #1;
        main_enable_o = en;
        aux_wake_pin_o = aux;
    endtask : set_pins

    // Class bit follows the supply, never left at 5 V on a low rail
    task automatic set_supply(input srpm_mv_t input_supply_rail, input logic [7:0] st);
        @(posedge clk_i);
        #1;
        input_supply_rail_mv_o = input_supply_rail;
        write_reg(8'h00, {st[7:1], input_supply_rail >= 13'h10cc});
    endtask : set_supply

    task automatic program_default;
        write_reg(8'h0b, 8'h87);
    endtask : program_default

    // Auto bit must fall before it can rise again
    task automatic rerun_auto(input logic [7:0] code);
        write_reg(8'h0b, {1'b0, code[6:0]});
        write_reg(8'h0b, {1'b1, code[6:0]});
    endtask : rerun_auto
endmodule : srpm_host_model
